// >>> hw/reset_source_pkg.sv
// Shared constants of the reset source controller: register offsets,
// legal codes, field positions, reset values and timing counts.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package reset_source_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_NS       = 20;
   localparam int SOFT_RESET_DELAY_NS = 20000;
   localparam int SOFT_RESET_CYCLES   =
      (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BROWNOUT_FILTER_NS  = 60000;
   localparam int BROWNOUT_CYCLES     =
      (BROWNOUT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_DELAY_NS    = 50000;
   localparam int RELEASE_CYCLES      =
      (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W               = 12;

   // ==========================================================
   // register map (byte addresses)
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_FUNC_SEL  = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_FLAGS     = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_THR_SEL   = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_WDT_CTRL  = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h010;

   // ==========================================================
   // codes and reset values
   localparam logic [7:0] FUNC_SEL_IO   = 8'h55;
   localparam logic [7:0] FUNC_SEL_PIN  = 8'hAA;
   localparam logic [7:0] FUNC_SEL_POR  = 8'h55;
   localparam logic [7:0] THR_CODE_0    = 8'h55;
   localparam logic [7:0] THR_CODE_1    = 8'h33;
   localparam logic [7:0] THR_CODE_2    = 8'h99;
   localparam logic [7:0] THR_CODE_3    = 8'hAA;
   localparam logic [7:0] THR_SEL_POR   = 8'h55;
   localparam logic [7:0] WDT_CTRL_POR  = 8'h53;
   localparam logic [4:0] WDT_EN_CODE   = 5'h0A;
   localparam logic [4:0] WDT_DIS_CODE  = 5'h15;
   localparam int         WDT_EN_LSB    = 3;
   localparam int         WDT_EN_MSB    = 7;
   localparam int         WDT_WS_MSB    = 2;

   // ==========================================================
   // flag register fields
   localparam int         FLAGS_W       = 4;
   localparam logic [3:0] FLAGS_POR     = 4'h0;
   localparam int         FLAG_WDT_BIT  = 0;
   localparam int         FLAG_THR_BIT  = 1;
   localparam int         FLAG_BO_BIT   = 2;
   localparam int         FLAG_FUNC_BIT = 3;
   localparam int         STAT_TO_BIT   = 0;
   localparam int         STAT_PD_BIT   = 1;

   // ==========================================================
   // enumerations
   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'b00,
      MODE_SLOW   = 2'b01,
      MODE_IDLE   = 2'b10,
      MODE_SLEEP  = 2'b11
   } mode_type;

   typedef enum logic [1:0]
   {
      ST_RUN     = 2'b00,
      ST_HOLD    = 2'b01,
      ST_RELEASE = 2'b10
   } state_type;

endpackage : reset_source_pkg

// >>> hw/hold_timer_if.sv
// Carrier between the controller and its persistence timers.
// Assumes both ends run on the one system clock.
`timescale 1ns/10ps
interface hold_timer_if;
   logic arm;
   logic expired;
   modport owner (output arm, input expired);
   modport timer (input arm, output expired);
endinterface : hold_timer_if

// >>> hw/persist_timer.sv
// Persistence timer: flags that its arm input has stood high long enough.
// Assumes a synchronous active-high reset and an arm held as a level.
`timescale 1ns/10ps
module persist_timer
   import reset_source_pkg::*;
#(
   parameter int unsigned LIMIT = 1
)
(
   input  wire logic  clk_i,
   input  wire logic  reset_i,
   hold_timer_if.timer tmr
);
   import reset_source_pkg::*;

   localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

   logic [CNT_W-1:0] cnt_r;
   logic             expired_r;

   // ==========================================================
   // count while armed, restart whenever arm drops
   always_ff @(posedge clk_i)
   begin
      if (reset_i || !tmr.arm)
         cnt_r <= '0;
      else if (cnt_r != LIM)
         cnt_r <= cnt_r + 1'b1;
   end

   // expiry is registered so the owner sees a clean level
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         expired_r <= 1'b0;
      else
         expired_r <= tmr.arm && (cnt_r == LIM);
   end

   assign tmr.expired = expired_r;

endmodule : persist_timer

// >>> hw/reset_source_control.sv
// Reset source controller: merges pin, brown-out, USB, watchdog and
// corrupted-register resets into one device reset with cause flags.
// Assumes inputs synchronous to clk_i; reset_i is the power-on reset.
//
// Notes on behaviour
// - function select outside its two legal codes resets after soft delay.
// - code 55h makes reset pin plain I/O, code AAh makes it reset.
// - function select powers up 55h; every reset but sleep warm restores.
// - illegal function code reset sets flag bit 3; software clears by zero.
// - pin driven low while selected resets the device; PC restarts at zero.
// - after pin rises the device waits an extra release delay; the code starts that delay once the pin reset restores 55h, not on pin rise.
// - brown-out detection always active in normal and slow modes.
// - brown-out detection disabled in idle and sleep modes.
// - low supply resets only when lasting beyond the filter time.
// - brown-out reset sets flag bit 2; software clears it by zero.
// - genuine brown-out reset leaves threshold select unchanged.
// - four legal threshold codes pick levels lowest to highest.
// - illegal threshold code resets after soft delay and restores 55h.
// - illegal threshold code sets flag bit 1; software clears by zero.
// - USB reset request resets the whole device.
// - watchdog time-out in normal or slow resets and sets time-out flag.
// - watchdog time-out asleep clears PC and SP, sets both status flags.
// - power-on clears both status flags; other resets keep them.
// - power-on disables interrupt enables and turns timers off.
// - power-on clears watchdog and time bases; watchdog then counts.
// - power-on makes ports inputs and points stack to its top.
// - illegal watchdog enable field requests a device reset.
// - illegal watchdog enable code sets flag bit 0; cleared by zero.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module reset_source_control
(
   input  wire logic                              clk_i,
   input  wire logic                              reset_i,
   // apb slave
   input  wire logic                              psel_i,
   input  wire logic                              penable_i,
   input  wire logic                              pwrite_i,
   input  wire logic [reset_source_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]                       pwdata_i,
   output logic      [31:0]                       prdata_o,
   output logic                                   pready_o,
   output logic                                   pslverr_o,
   // reset sources
   input  wire logic                              external_reset_pin_n_i,
   input  wire logic                              supply_low_i,
   input  wire logic                              usb_reset_req_i,
   input  wire logic                              watchdog_timeout_i,
   input  wire reset_source_pkg::mode_type        mode_i,
   // reset results and controls
   output logic                                   device_reset_o,
   output logic                                   pc_sp_clear_o,
   output logic                                   por_init_o,
   output logic                                   reset_pin_is_io_o,
   output logic                                   brownout_enable_o,
   output logic      [1:0]                        threshold_level_o,
   output logic                                   watchdog_enable_o,
   output logic                                   watchdog_clear_o,
   output logic      [2:0]                        watchdog_period_o,
   output logic                                   timeout_status_flag_o,
   output logic                                   powerdown_status_flag_o
);
   import reset_source_pkg::*;

   localparam int SOFT_MAX = 1010;
   localparam logic [CNT_W-1:0] REL_LAST = CNT_W'(RELEASE_CYCLES - 1);

   // ==========================================================
   // code checks used by decode, pending logic and checks
   function automatic logic func_sel_legal(input logic [7:0] v);
      func_sel_legal = (v == FUNC_SEL_IO) || (v == FUNC_SEL_PIN);
   endfunction : func_sel_legal

   function automatic logic thr_sel_legal(input logic [7:0] v);
      thr_sel_legal = (v == THR_CODE_0) || (v == THR_CODE_1) ||
                      (v == THR_CODE_2) || (v == THR_CODE_3);
   endfunction : thr_sel_legal

   function automatic logic [1:0] thr_level(input logic [7:0] v);
      case (v)
         THR_CODE_1: thr_level = 2'h1;
         THR_CODE_2: thr_level = 2'h2;
         THR_CODE_3: thr_level = 2'h3;
         default:    thr_level = 2'h0;
      endcase
   endfunction : thr_level

   function automatic logic wdt_code_legal(input logic [7:0] v);
      wdt_code_legal = (v[WDT_EN_MSB:WDT_EN_LSB] == WDT_EN_CODE) ||
                       (v[WDT_EN_MSB:WDT_EN_LSB] == WDT_DIS_CODE);
   endfunction : wdt_code_legal

   // ==========================================================
   // state
   state_type        state_r;
   state_type        state_nxt;
   logic [CNT_W-1:0] rel_cnt_r;
   logic [7:0]       reset_function_select_r;
   logic [7:0]       brownout_threshold_select_r;
   logic [7:0]       watchdog_control_reg_r;
   logic [3:0]       reset_cause_flags_r;
   logic [3:0]       flag_set;
   logic             timeout_flag_r;
   logic             powerdown_flag_r;
   logic             pend_func_r;
   logic             pend_thr_r;
   logic             pend_wdt_r;
   logic             warm_clear_r;
   logic             por_init_r;
   logic [31:0]      rd_data_r;

   logic sleepy;
   logic pin_reset;
   logic bo_arm;
   logic bo_fire;
   logic soft_fire;
   logic wdt_normal;
   logic wdt_sleep;
   logic other_reset;
   logic start_reset;
   logic hold_level;
   logic apb_access;
   logic addr_hit;
   logic wr_en;

   hold_timer_if bo_tmr ();
   hold_timer_if soft_tmr ();

   // ==========================================================
   // reset source decode
   assign sleepy      = (mode_i == MODE_IDLE) || (mode_i == MODE_SLEEP);
   assign brownout_enable_o = !sleepy;
   assign pin_reset   = (reset_function_select_r == FUNC_SEL_PIN) &&
                        !external_reset_pin_n_i;
   assign bo_arm      = brownout_enable_o && supply_low_i;
   assign bo_tmr.arm  = bo_arm;
   assign bo_fire     = bo_tmr.expired && bo_arm;
   assign soft_tmr.arm = pend_func_r || pend_thr_r || pend_wdt_r;
   // pending qualifies expiry so one request fires exactly once
   assign soft_fire   = soft_tmr.expired && soft_tmr.arm;
   assign wdt_normal  = watchdog_timeout_i && !sleepy;
   assign wdt_sleep   = watchdog_timeout_i && sleepy;
   assign other_reset = pin_reset || usb_reset_req_i ||
                        wdt_normal || soft_fire;
   assign start_reset = other_reset || bo_fire;
   assign hold_level  = pin_reset || bo_arm;

   // brown-out must persist past the filter time
   persist_timer #(
      .LIMIT (BROWNOUT_CYCLES)
   ) u_bo_filter (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tmr     (bo_tmr)
   );

   // delay between a corrupted code and its reset
   persist_timer #(
      .LIMIT (SOFT_RESET_CYCLES)
   ) u_soft_delay (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tmr     (soft_tmr)
   );

   // ==========================================================
   // corrupted-code requests latch until their reset fires
   always_ff @(posedge clk_i)
   begin
      if (reset_i || soft_fire)
      begin
         pend_func_r <= 1'b0;
         pend_thr_r  <= 1'b0;
         pend_wdt_r  <= 1'b0;
      end
      else
      begin
         // later legal writes cannot cancel a latched request
         pend_func_r <= pend_func_r ||
                        !func_sel_legal(reset_function_select_r);
         pend_thr_r  <= pend_thr_r ||
                        !thr_sel_legal(brownout_threshold_select_r);
         pend_wdt_r  <= pend_wdt_r ||
                        !wdt_code_legal(watchdog_control_reg_r);
      end
   end

   // ==========================================================
   // reset sequencer
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
            if (start_reset)
               state_nxt = ST_HOLD;
         ST_HOLD:
            if (!hold_level)
               state_nxt = ST_RELEASE;
         ST_RELEASE:
            if (start_reset)
               state_nxt = ST_HOLD;
            else if (rel_cnt_r == REL_LAST)
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   // power-on also walks through the release delay
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         state_r <= ST_RELEASE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_r != ST_RELEASE || start_reset)
         rel_cnt_r <= '0;
      else
         rel_cnt_r <= rel_cnt_r + 1'b1;
   end

   // power-on initialisation lasts through the first run cycle
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         por_init_r <= 1'b1;
      else if (state_r == ST_RUN)
         por_init_r <= 1'b0;
   end

   // warm clear: only PC and SP, rest of the device keeps running
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         warm_clear_r <= 1'b0;
      else
         warm_clear_r <= wdt_sleep && (state_r == ST_RUN);
   end

   // ==========================================================
   // apb slave: zero wait states, read data captured in setup
   assign apb_access = psel_i && penable_i;
   assign addr_hit   = (paddr_i == OFS_FUNC_SEL) || (paddr_i == OFS_FLAGS) ||
                       (paddr_i == OFS_THR_SEL) ||
                       (paddr_i == OFS_WDT_CTRL) || (paddr_i == OFS_STATUS);
   assign wr_en      = apb_access && pwrite_i;
   assign pready_o   = apb_access;
   assign pslverr_o  = apb_access && !addr_hit;
   assign prdata_o   = rd_data_r;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rd_data_r <= '0;
      else if (psel_i && !penable_i)
         case (paddr_i)
            OFS_FUNC_SEL: rd_data_r <= {24'h0, reset_function_select_r};
            OFS_FLAGS:    rd_data_r <= {28'h0, reset_cause_flags_r};
            OFS_THR_SEL:  rd_data_r <= {24'h0, brownout_threshold_select_r};
            OFS_WDT_CTRL: rd_data_r <= {24'h0, watchdog_control_reg_r};
            OFS_STATUS:   rd_data_r <= {28'h0, state_r,
                                        powerdown_flag_r, timeout_flag_r};
            default:      rd_data_r <= '0;
         endcase
   end

   // ==========================================================
   // control registers; a reset restore beats a same-cycle write
   always_ff @(posedge clk_i)
   begin
      if (reset_i || start_reset)
         reset_function_select_r <= FUNC_SEL_POR;
      else if (wr_en && paddr_i == OFS_FUNC_SEL)
         reset_function_select_r <= pwdata_i[7:0];
   end

   // a genuine brown-out alone keeps the chosen threshold
   always_ff @(posedge clk_i)
   begin
      if (reset_i || other_reset)
         brownout_threshold_select_r <= THR_SEL_POR;
      else if (wr_en && paddr_i == OFS_THR_SEL)
         brownout_threshold_select_r <= pwdata_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i || start_reset)
         watchdog_control_reg_r <= WDT_CTRL_POR;
      else if (wr_en && paddr_i == OFS_WDT_CTRL)
         watchdog_control_reg_r <= pwdata_i[7:0];
   end

   // ==========================================================
   // cause flags: writing zero clears, writing one does nothing,
   // and a hardware set in the same cycle wins
   always_comb
   begin
      flag_set = '0;
      flag_set[FLAG_FUNC_BIT] = soft_fire && pend_func_r;
      flag_set[FLAG_BO_BIT]   = bo_fire;
      flag_set[FLAG_THR_BIT]  = soft_fire && pend_thr_r;
      flag_set[FLAG_WDT_BIT]  = soft_fire && pend_wdt_r;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         reset_cause_flags_r <= FLAGS_POR;
      else if (wr_en && paddr_i == OFS_FLAGS)
         reset_cause_flags_r <= (reset_cause_flags_r &
                                 pwdata_i[FLAGS_W-1:0]) | flag_set;
      else
         reset_cause_flags_r <= reset_cause_flags_r | flag_set;
   end

   // status flags: only power-on clears them
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         timeout_flag_r   <= 1'b0;
         powerdown_flag_r <= 1'b0;
      end
      else
      begin
         timeout_flag_r   <= timeout_flag_r || watchdog_timeout_i;
         powerdown_flag_r <= powerdown_flag_r || wdt_sleep;
      end
   end

   // ==========================================================
   // outputs
   assign device_reset_o          = (state_r != ST_RUN);
   assign pc_sp_clear_o           = device_reset_o || warm_clear_r;
   assign por_init_o              = por_init_r;
   assign reset_pin_is_io_o       = (reset_function_select_r == FUNC_SEL_IO);
   assign threshold_level_o       = thr_level(brownout_threshold_select_r);
   // watchdog counters held clear in reset, counting from first run cycle
   assign watchdog_clear_o        = device_reset_o;
   assign watchdog_enable_o       = (state_r == ST_RUN) &&
      (watchdog_control_reg_r[WDT_EN_MSB:WDT_EN_LSB] == WDT_EN_CODE);
   assign watchdog_period_o       = watchdog_control_reg_r[WDT_WS_MSB:0];
   assign timeout_status_flag_o   = timeout_flag_r;
   assign powerdown_status_flag_o = powerdown_flag_r;

   // ==========================================================
   // checks
   logic [CNT_W-1:0] low_run_r;
   always_ff @(posedge clk_i)
   begin
      if (reset_i || !bo_arm)
         low_run_r <= '0;
      else if (low_run_r != {CNT_W{1'b1}})
         low_run_r <= low_run_r + 1'b1;
   end

   // run cycles a corrupted code has stood; too long to unroll as a range
   logic [CNT_W-1:0] func_wait_r;
   logic [CNT_W-1:0] wdt_wait_r;
   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_r != ST_RUN ||
          func_sel_legal(reset_function_select_r))
         func_wait_r <= '0;
      else
         func_wait_r <= func_wait_r + 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_r != ST_RUN ||
          wdt_code_legal(watchdog_control_reg_r))
         wdt_wait_r <= '0;
      else
         wdt_wait_r <= wdt_wait_r + 1'b1;
   end

   illegal_func_a: assert property (@(posedge clk_i) disable iff (reset_i)
      func_wait_r < CNT_W'(SOFT_MAX))
      else $error("corrupt function code did not reset");

   func_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (soft_fire && pend_func_r) |=> reset_cause_flags_r[FLAG_FUNC_BIT]
         && reset_function_select_r == FUNC_SEL_POR)
      else $error("function code flag not set");

   flag_one_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_en && paddr_i == OFS_FLAGS && !reset_cause_flags_r[FLAG_WDT_BIT]
         && !flag_set[FLAG_WDT_BIT]) |=> !reset_cause_flags_r[FLAG_WDT_BIT])
      else $error("writing one set a cause flag");

   pin_reset_a: assert property (@(posedge clk_i) disable iff (reset_i)
      pin_reset |=> device_reset_o)
      else $error("pin low did not reset");

   release_wait_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_r == ST_HOLD && !hold_level && !start_reset)
      |=> (device_reset_o [*8]))
      else $error("release delay cut short");

   bo_sleep_a: assert property (@(posedge clk_i) disable iff (reset_i)
      sleepy |-> !brownout_enable_o && !bo_fire)
      else $error("brown-out active while asleep");

   bo_filter_a: assert property (@(posedge clk_i) disable iff (reset_i)
      bo_fire |-> low_run_r >= CNT_W'(BROWNOUT_CYCLES))
      else $error("brown-out fired before filter time");

   bo_keep_thr_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (bo_fire && !other_reset && !wr_en) |=>
      brownout_threshold_select_r == $past(brownout_threshold_select_r)
         && reset_cause_flags_r[FLAG_BO_BIT])
      else $error("brown-out changed threshold select");

   thr_restore_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (soft_fire && pend_thr_r) |=>
      brownout_threshold_select_r == THR_SEL_POR
         && reset_cause_flags_r[FLAG_THR_BIT])
      else $error("corrupt threshold not restored");

   wdt_run_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (wdt_normal && state_r == ST_RUN) |=>
      state_r == ST_HOLD && timeout_status_flag_o)
      else $error("watchdog time-out did not reset");

   wdt_sleep_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (wdt_sleep && state_r == ST_RUN && !start_reset) |=>
      pc_sp_clear_o && !device_reset_o && timeout_status_flag_o
         && powerdown_status_flag_o)
      else $error("warm watchdog clear wrong");

   wdt_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
      wdt_wait_r < CNT_W'(SOFT_MAX))
      else $error("corrupt watchdog code did not reset");

endmodule : reset_source_control

// >>> dv/pin_supply_model.sv
// Far side: reset pin rc network and supply comparator, driven on command.
// Assumes the bench raises the commands just after a rising clock edge.
`timescale 1ns/10ps
module pin_supply_model
(
   input  wire logic clk_i,
   input  wire logic pin_low_i,
   input  wire logic dip_i,
   output logic      external_reset_pin_n_o = 1'b1,
   output logic      supply_low_o = 1'b0
);
   // ==================================================
   // pin pulled low by outside circuit; supply dips
   always @(posedge clk_i)
   begin
      external_reset_pin_n_o <= ~pin_low_i;
      supply_low_o           <= dip_i;
   end
endmodule : pin_supply_model

// >>> dv/tb_top.sv
// Self-checking bench of the reset source controller over APB.
// Assumes the pin and supply model beside the design, 50 MHz clock.
`timescale 1ns/10ps
module tb_top;
   import reset_source_pkg::*;
   // ==================================================
   // stimulus, model and design wiring
   logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic usb_reset_req_i = 0, watchdog_timeout_i = 0, pin = 0, dip = 0;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, q, prdata_o;
   mode_type mode_i = MODE_NORMAL;
   logic external_reset_pin_n_i, supply_low_i, pready_o, pslverr_o, perr;
   logic device_reset_o, pc_sp_clear_o, reset_pin_is_io_o;
   logic brownout_enable_o, timeout_status_flag_o, powerdown_status_flag_o;
   logic [1:0] threshold_level_o;
   logic por_init_o, watchdog_enable_o, watchdog_clear_o;
   logic [2:0] watchdog_period_o;
   int fails = 0, samples_checked = 0;
   always #10 clk_i = ~clk_i;
   pin_supply_model m (.clk_i, .pin_low_i(pin), .dip_i(dip),
      .external_reset_pin_n_o(external_reset_pin_n_i),
      .supply_low_o(supply_low_i));
   reset_source_control dut (.clk_i, .reset_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .external_reset_pin_n_i, .supply_low_i, .usb_reset_req_i,
      .watchdog_timeout_i, .mode_i, .device_reset_o, .pc_sp_clear_o,
      .por_init_o, .reset_pin_is_io_o, .brownout_enable_o,
      .threshold_level_o, .watchdog_enable_o, .watchdog_clear_o,
      .watchdog_period_o, .timeout_status_flag_o,
      .powerdown_status_flag_o);
   // ==================================================
   // bus cycle, comparison and expectation helpers
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i    <= 1;
      penable_i <= 0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      perr = pslverr_o;
      psel_i    <= 0;
      penable_i <= 0;
      #1;
   endtask : apb
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fails++;
         $display("BAD at %0t: seen %h want %h", $time, s, e);
      end
   endtask : chk
   // bounded wait for the reset output to reach a level
   task wait_lvl(input logic v, input int lim);
      for (int n = 0; n < lim && device_reset_o !== v; n++)
      begin
         @(posedge clk_i);
         #1;
      end
   endtask : wait_lvl
   function logic [1:0] thr_lvl(input logic [7:0] c);
      return c == THR_CODE_1 ? 2'h1 : c == THR_CODE_2 ? 2'h2 :
             c == THR_CODE_3 ? 2'h3 : 2'h0;
   endfunction : thr_lvl
   task results;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   // ==================================================
   // hang guard, far beyond the longest sequence
   initial
   begin
      #1000000;
      fails++;
      results;
   end
   // ==================================================
   // main sequence
   initial
   begin
      logic [7:0] bad;
      logic [7:0] codes [4] = '{THR_CODE_0, THR_CODE_1, THR_CODE_2,
                                THR_CODE_3};
      bad = $urandom(63);
      repeat (12) @(posedge clk_i);
      chk({por_init_o, watchdog_clear_o}, 32'h3);
      reset_i <= 0;
      wait_lvl(0, 3000);
      apb(0, OFS_FUNC_SEL, 0);
      chk(q, 32'h55);
      apb(0, OFS_STATUS, 0);
      chk(q, 32'h0);
      chk({watchdog_enable_o, watchdog_period_o}, 32'hB);
      chk(por_init_o | watchdog_clear_o, 32'h0);
      apb(1, 12'h020, 32'hFF);
      chk(perr, 32'h1);
      chk(brownout_enable_o, 32'h1);
      foreach (codes[i])
      begin
         apb(1, OFS_THR_SEL, codes[i]);
         chk(threshold_level_o, thr_lvl(codes[i]));
      end
      $display("test registers done");
      apb(1, OFS_FUNC_SEL, FUNC_SEL_PIN);
      chk(reset_pin_is_io_o, 32'h0);
      @(posedge clk_i);
      pin <= 1;
      wait_lvl(1, 10);
      chk(device_reset_o, 32'h1);
      repeat (200) @(posedge clk_i);
      pin <= 0;
      repeat (2200) @(posedge clk_i);
      chk(device_reset_o, 32'h1);
      wait_lvl(0, 300);
      chk(device_reset_o, 32'h0);
      chk(reset_pin_is_io_o, 32'h1);
      $display("test pin reset done");
      do bad = $urandom; while (bad == FUNC_SEL_IO || bad == FUNC_SEL_PIN);
      apb(1, OFS_FUNC_SEL, bad);
      repeat (900) @(posedge clk_i);
      chk(device_reset_o, 32'h0);
      apb(1, OFS_FUNC_SEL, FUNC_SEL_IO);
      wait_lvl(1, 200);
      chk(device_reset_o, 32'h1);
      wait_lvl(0, 3000);
      apb(1, OFS_FLAGS, 32'hF);
      apb(0, OFS_FLAGS, 0);
      chk(q, 32'h8);
      apb(1, OFS_FLAGS, 0);
      $display("test bad code done");
      bad = codes[$urandom % 4];
      apb(1, OFS_THR_SEL, bad);
      @(posedge clk_i);
      dip <= 1;
      repeat (1000) @(posedge clk_i);
      dip <= 0;
      mode_i <= MODE_IDLE;
      chk(device_reset_o, 32'h0);
      repeat (4) @(posedge clk_i);
      dip <= 1;
      repeat (3500) @(posedge clk_i);
      chk(device_reset_o | brownout_enable_o, 32'h0);
      dip <= 0;
      mode_i <= MODE_NORMAL;
      repeat (4) @(posedge clk_i);
      dip <= 1;
      wait_lvl(1, 3200);
      chk(device_reset_o, 32'h1);
      dip <= 0;
      wait_lvl(0, 3000);
      apb(0, OFS_FLAGS, 0);
      chk(q, 32'h4);
      apb(0, OFS_THR_SEL, 0);
      chk(q, bad);
      $display("test brown-out done");
      mode_i <= MODE_SLEEP;
      watchdog_timeout_i <= 1;
      @(posedge clk_i);
      watchdog_timeout_i <= 0;
      #1;
      chk({device_reset_o, pc_sp_clear_o}, 32'h1);
      chk({timeout_status_flag_o, powerdown_status_flag_o}, 32'h3);
      @(posedge clk_i);
      mode_i <= MODE_NORMAL;
      usb_reset_req_i <= 1;
      @(posedge clk_i);
      usb_reset_req_i <= 0;
      #1;
      chk(device_reset_o, 32'h1);
      chk(powerdown_status_flag_o, 32'h1);
      wait_lvl(0, 3000);
      $display("test warm resets done");
      @(posedge clk_i);
      reset_i <= 1;
      repeat (2) @(posedge clk_i);
      chk({por_init_o, timeout_status_flag_o, powerdown_status_flag_o},
          32'h4);
      reset_i <= 0;
      $display("test power-on again done");
      results;
   end
endmodule : tb_top
